// ### logic/mtom_monitor.v
// Purpose: Motor thermal overload monitor with two motor models
// Assumes: ref_clk 100 MHz, rst synchronous active high
// Notes:   Currents in 0.01 A; both models share one tick
// How it works
// R01 - Select input uses second rated current
// R02 - Input selector code 3 routes select
// R03 - Selected valid motor integrates real current
// R04 - Unselected active motor integrates zero current
// R05 - Zero rated current disables that model
// R06 - Second current 0.01-500A, 0, 9999
// R07 - Both 9999: select keeps first motor
// R08 - 85 percent level raises alarm output
// R09 - 100 percent level trips overload fault
// R10 - Alarm alone never trips drive
// R11 - Output selector 8 positive, 108 negative
// R12 - Applied motor codes, default 0
// R13 - Second motor 0/1, 9999 fallback
// R14 - Flux vector uses applied motor constants
// R15 - Motor selectors writable when group zero
// R16 - Fault cleared only by resets
// R17 - Periodic tick, cooling saturates at zero
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "mtom_regs.vh"

module mtom_monitor #(
   parameter [19:0] CUR1_INIT  = 20'h2710,
   parameter        TICK_CYC   = `MTOM_TICK_NS / `MTOM_CLK_NS,
   parameter [5:0]  SHIFT_STD  = 6'h06,
   parameter [5:0]  SHIFT_CT   = 6'h08
)(
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [4:0]  inTerm,
   input  wire        resetIn,
   input  wire [19:0] outCurrent,
   output wire [5:0]  outTerm,
   output wire        thermalAlarmOut,
   output wire        thermalPrealarmIndication,
   output wire        motorOverloadFault,
   output wire [15:0] motorConstSel,
   output wire        motorConstValid,
   output wire        irq
);

   // Byte-lane merge of a write into a base word; wMerge passes zero as the base
   function [31:0] mergeW;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      i;
      begin
         mergeW = old;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
               mergeW[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   // Constant-torque thermal characteristic codes
   function ctChar;
      input [15:0] s;
      begin
         ctChar = (s == 16'h0001) || (s >= 16'h000D && s <= 16'h0010) ||
                  (s == 16'h0032) || (s == 16'h0035) || (s == 16'h0036);
      end
   endfunction

   // Legal applied motor codes
   function selOk;
      input [15:0] s;
      begin
         selOk = (s <= 16'h0001) || (s >= 16'h0003 && s <= 16'h0006) ||
                 (s >= 16'h000D && s <= 16'h0010) ||
                 (s == 16'h0017) || (s == 16'h0018) ||
                 (s == 16'h0028) || (s == 16'h002B) ||
                 (s == 16'h002C) || ctChar(s);
      end
   endfunction

   // First-order heating step; never goes below zero
   function [39:0] stepAcc;
      input [39:0] acc;
      input [39:0] heat;
      input [5:0]  sh;
      begin
         stepAcc = acc - (acc >> sh) + (heat >> sh); // R17
      end
   endfunction

   // True when acc reaches pct percent of lvl
   function atPct;
      input [39:0] acc;
      input [39:0] lvl;
      input [6:0]  pct;
      begin
         atPct = ({7'h00, acc} * 47'h64) >=
                 ({7'h00, lvl} * {40'h0, pct});
      end
   endfunction

   // Settings registers
   reg  [19:0] cur1Ff;      // First rated current
   reg  [19:0] cur2Ff;      // Second rated current
   reg  [15:0] mselFf;      // Applied motor selector
   reg  [15:0] msel2Ff;     // Second applied motor selector
   reg  [15:0] ugrpFf;      // User group read selection
   reg  [29:0] inFnFf;      // Five 6-bit input selectors
   reg  [20:0] outFaFf;     // Three 7-bit output selectors
   reg  [20:0] outFbFf;     // Three more output selectors
   reg  [1:0]  stsFf;       // Sticky events
   reg  [1:0]  maskFf;      // Interrupt mask
   reg         ctrlFf;      // Flux vector control enable
   // Model state
   reg  [39:0] acc1Ff;      // First motor accumulator
   reg  [39:0] acc2Ff;      // Second motor accumulator
   reg         faultFf;     // Latched overload trip
   reg         alarmFf;     // Prealarm level reached
   reg  [31:0] tickCntFf;   // Tick divider
   reg  [5:0]  outTermFf;   // Registered output terminals
   // Bus state
   reg  [7:0]  awAddrFf;
   reg         awHeldFf;
   reg  [31:0] wDataFf;
   reg  [3:0]  wStrbFf;
   reg         wHeldFf;
   reg         bValidFf;
   reg  [1:0]  bRespFf;
   reg         rValidFf;
   reg  [31:0] rDataFf;
   reg  [1:0]  rRespFf;

   // Second-set select from any terminal coded for it
   reg         secSel;
   integer     k;
   always @*
   begin
      secSel = 1'b0;
      for (k = 0; k < 5; k = k + 1)
      begin
         if (inFnFf[k*6 +: 6] == `MTOM_CODE_RT && inTerm[k])
            secSel = 1'b1; // R02
      end
   end

   // Activity table decode
   wire        m450    = (msel2Ff != `MTOM_SEL2_OFF);
   wire        cur2Inv = (cur2Ff == `MTOM_CUR_INV);
   // An invalid second current borrows the first when motor 2 is set
   wire [19:0] cur2Eff = cur2Inv ? (m450 ? cur1Ff : `MTOM_CUR_INV)
                                 : cur2Ff;
   wire        m1Act   = (cur1Ff != 20'h0);                 // R05
   wire        m2Act   = (cur2Eff != 20'h0) &&
                         (cur2Eff != `MTOM_CUR_INV);        // R05
   // Select is ignored when the second set is wholly unused
   wire        useSec  = secSel && !(cur2Inv && !m450);     // R07
   wire        m1Real  = m1Act && !useSec;                  // R03
   wire        m1Cool  = m1Act && useSec;                   // R04
   wire        m2Real  = m2Act && useSec;                   // R01
   wire        m2Cool  = m2Act && !useSec;                  // R04

   // Thermal characteristic per motor
   wire [15:0] sel2Eff = m450 ? msel2Ff : mselFf;           // R13
   wire [5:0]  sh1     = ctChar(mselFf) ? SHIFT_CT : SHIFT_STD;
   wire [5:0]  sh2     = ctChar(sel2Eff) ? SHIFT_CT : SHIFT_STD;

   // Heat input and levels, squared current
   wire [39:0] heat    = {20'h0, outCurrent} * {20'h0, outCurrent};
   wire [39:0] lvl1    = {20'h0, cur1Ff} * {20'h0, cur1Ff};
   wire [39:0] lvl2    = {20'h0, cur2Eff} * {20'h0, cur2Eff};
   wire        tick    = (tickCntFf == TICK_CYC - 1);

   // Level detectors for active models only
   wire        pre1    = m1Act && atPct(acc1Ff, lvl1, `MTOM_PCT_PRE);
   wire        pre2    = m2Act && atPct(acc2Ff, lvl2, `MTOM_PCT_PRE);
   wire        trip1   = m1Act && atPct(acc1Ff, lvl1, `MTOM_PCT_TRIP);
   wire        trip2   = m2Act && atPct(acc2Ff, lvl2, `MTOM_PCT_TRIP);
   wire        nxt_alarm = pre1 || pre2;                    // R08

   // Tick divider and accumulators
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         tickCntFf <= 32'h0;
         acc1Ff    <= 40'h0;
         acc2Ff    <= 40'h0;
      end
      else
      begin
         tickCntFf <= tick ? 32'h0 : tickCntFf + 32'h1;     // R17
         if (tick)
         begin
            // Inactive models hold nothing
            if (m1Real)
               acc1Ff <= stepAcc(acc1Ff, heat, sh1);        // R03
            else if (m1Cool)
               acc1Ff <= stepAcc(acc1Ff, 40'h0, sh1);       // R04
            else
               acc1Ff <= 40'h0;                             // R05
            if (m2Real)
               acc2Ff <= stepAcc(acc2Ff, heat, sh2);        // R01
            else if (m2Cool)
               acc2Ff <= stepAcc(acc2Ff, 40'h0, sh2);       // R04
            else
               acc2Ff <= 40'h0;                             // R05
         end
      end
   end

   // Alarm and fault; only reaching 100 percent trips
   always @(posedge ref_clk)
   begin
      if (rst || resetIn)
      begin
         faultFf <= 1'b0;                                   // R16
         alarmFf <= 1'b0;
      end
      else
      begin
         alarmFf <= nxt_alarm;                              // R10
         if (trip1 || trip2)
            faultFf <= 1'b1;                                // R09
      end
   end

   // Output terminal mapping, registered
   reg [5:0] nxt_outTerm;
   reg [6:0] code;
   integer   j;
   always @*
   begin
      nxt_outTerm = 6'h0;
      code        = 7'h0;
      for (j = 0; j < 6; j = j + 1)
      begin
         code = (j < 3) ? outFaFf[j*7 +: 7] : outFbFf[(j-3)*7 +: 7];
         if (code == `MTOM_CODE_POS)
            nxt_outTerm[j] = alarmFf;                       // R11
         else if (code == `MTOM_CODE_NEG)
            nxt_outTerm[j] = !alarmFf;                      // R11
      end
   end

   always @(posedge ref_clk)
   begin
      if (rst)
         outTermFf <= 6'h0;
      else
         outTermFf <= nxt_outTerm;
   end

   // AXI write channels: both halves held, then one response
   wire        wrGo   = awHeldFf && wHeldFf && !bValidFf;
   wire [31:0] wMerge = mergeW(32'h0, wDataFf, wStrbFf);
   wire        grpOk  = (ugrpFf == 16'h0);                  // R15
   wire [15:0] wLow   = wMerge[15:0];
   wire [19:0] wCur   = wMerge[19:0];
   wire        curOk  = (wCur <= `MTOM_CUR_MAX);
   wire        cur2Ok = curOk || (wCur == `MTOM_CUR_INV);   // R06
   wire        sel2Ok = (wLow <= 16'h0001) ||
                        (wLow == `MTOM_SEL2_OFF);           // R13

   // Write decode; refused values keep the old setting
   reg         wrRef;
   reg         wrMap;
   always @*
   begin
      wrMap = 1'b1;
      wrRef = 1'b0;
      case (awAddrFf)
         `MTOM_A_CUR1:  wrRef = !curOk;
         `MTOM_A_CUR2:  wrRef = !cur2Ok;
         `MTOM_A_MSEL:  wrRef = !grpOk || !selOk(wLow);     // R12
         `MTOM_A_MSEL2: wrRef = !grpOk || !sel2Ok;          // R15
         `MTOM_A_UGRP,
         `MTOM_A_INFN,
         `MTOM_A_OUTFA,
         `MTOM_A_OUTFB,
         `MTOM_A_MASK,
         `MTOM_A_CTRL:  wrRef = 1'b0;
         default:       wrMap = 1'b0;
      endcase
   end

   wire wrDo = wrGo && wrMap && !wrRef;

   // Settings storage
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         cur1Ff  <= CUR1_INIT;
         cur2Ff  <= `MTOM_CUR2_RST;                         // R06
         mselFf  <= `MTOM_MSEL_RST;                         // R12
         msel2Ff <= `MTOM_SEL2_OFF;                         // R13
         ugrpFf  <= 16'h0;
         inFnFf  <= 30'h0;
         outFaFf <= 21'h0;
         outFbFf <= 21'h0;
         maskFf  <= 2'h0;
         ctrlFf  <= 1'b0;
      end
      else if (wrDo)
      begin
         case (awAddrFf)
            `MTOM_A_CUR1:  cur1Ff  <= wCur;
            `MTOM_A_CUR2:  cur2Ff  <= wCur;
            `MTOM_A_MSEL:  mselFf  <= wLow;
            `MTOM_A_MSEL2: msel2Ff <= wLow;
            `MTOM_A_UGRP:  ugrpFf  <= wLow;
            `MTOM_A_INFN:  inFnFf  <= wMerge[29:0];
            `MTOM_A_OUTFA: outFaFf <= wMerge[20:0];
            `MTOM_A_OUTFB: outFbFf <= wMerge[20:0];
            `MTOM_A_MASK:  maskFf  <= wMerge[1:0];
            `MTOM_A_CTRL:  ctrlFf  <= wMerge[0];
            default:       ctrlFf  <= ctrlFf;
         endcase
      end
   end

   // Write handshake state
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         awAddrFf <= 8'h0;
         awHeldFf <= 1'b0;
         wDataFf  <= 32'h0;
         wStrbFf  <= 4'h0;
         wHeldFf  <= 1'b0;
         bValidFf <= 1'b0;
         bRespFf  <= 2'b00;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awAddrFf <= {s_axi_awaddr[7:2], 2'b00};
            awHeldFf <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wDataFf <= s_axi_wdata;
            wStrbFf <= s_axi_wstrb;
            wHeldFf <= 1'b1;
         end
         if (wrGo)
         begin
            awHeldFf <= 1'b0;
            wHeldFf  <= 1'b0;
            bValidFf <= 1'b1;
            // Unmapped gives DECERR, refused value SLVERR
            bRespFf  <= !wrMap ? 2'b11 : (wrRef ? 2'b10 : 2'b00);
         end
         else if (bValidFf && s_axi_bready)
            bValidFf <= 1'b0;
      end
   end

   // Read mux
   wire [7:0] rAddr = {s_axi_araddr[7:2], 2'b00};
   reg [31:0] rMux;
   reg        rMap;
   always @*
   begin
      rMap = 1'b1;
      rMux = 32'h0;
      case (rAddr)
         `MTOM_A_CUR1:  rMux = {12'h0, cur1Ff};
         `MTOM_A_CUR2:  rMux = {12'h0, cur2Ff};
         `MTOM_A_MSEL:  rMux = {16'h0, mselFf};
         `MTOM_A_MSEL2: rMux = {16'h0, msel2Ff};
         `MTOM_A_UGRP:  rMux = {16'h0, ugrpFf};
         `MTOM_A_INFN:  rMux = {2'h0, inFnFf};
         `MTOM_A_OUTFA: rMux = {11'h0, outFaFf};
         `MTOM_A_OUTFB: rMux = {11'h0, outFbFf};
         `MTOM_A_STS:   rMux = {30'h0, stsFf};
         `MTOM_A_MASK:  rMux = {30'h0, maskFf};
         `MTOM_A_STATE: rMux = {24'h0, ctChar(useSec ? sel2Eff : mselFf),
                                m2Cool, m1Cool, m2Act, m1Act,
                                useSec, faultFf, alarmFf};
         `MTOM_A_ACC1:  rMux = acc1Ff[39:8];
         `MTOM_A_ACC2:  rMux = acc2Ff[39:8];
         `MTOM_A_CTRL:  rMux = {31'h0, ctrlFf};
         default:       rMap = 1'b0;
      endcase
   end

   wire rdTake = s_axi_arvalid && s_axi_arready;
   wire stsRd  = rdTake && (rAddr == `MTOM_A_STS);

   // Read channel
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         rValidFf <= 1'b0;
         rDataFf  <= 32'h0;
         rRespFf  <= 2'b00;
      end
      else if (rdTake)
      begin
         rValidFf <= 1'b1;
         rDataFf  <= rMux;
         rRespFf  <= rMap ? 2'b00 : 2'b11;
      end
      else if (rValidFf && s_axi_rready)
         rValidFf <= 1'b0;
   end

   // Sticky events; a new event beats the read clear
   wire [1:0] stsSet = {trip1 || trip2, nxt_alarm && !alarmFf};
   always @(posedge ref_clk)
   begin
      if (rst)
         stsFf <= 2'h0;
      else
         stsFf <= (stsFf & ~{2{stsRd}}) | stsSet;
   end

   // Outputs
   assign s_axi_awready = !awHeldFf && !bValidFf;
   assign s_axi_wready  = !wHeldFf && !bValidFf;
   assign s_axi_bvalid  = bValidFf;
   assign s_axi_bresp   = bRespFf;
   assign s_axi_arready = !rValidFf;
   assign s_axi_rvalid  = rValidFf;
   assign s_axi_rdata   = rDataFf;
   assign s_axi_rresp   = rRespFf;
   assign outTerm                   = outTermFf;
   assign thermalAlarmOut           = alarmFf;              // R08
   assign thermalPrealarmIndication = alarmFf;
   assign motorOverloadFault        = faultFf;
   // Controller constants follow the motor in use
   assign motorConstSel   = useSec ? sel2Eff : mselFf;      // R14
   assign motorConstValid = ctrlFf;                         // R14
   assign irq             = |(stsFf & maskFf);

endmodule // mtom_monitor

// ### logic/mtom_regs.vh
// Purpose: Offsets, codes, reset values and timing for the monitor
// Assumes: 32-bit AXI4-Lite, one aligned word per register
// Notes:   Currents are in units of 0.01 A
`ifndef MTOM_REGS_VH
`define MTOM_REGS_VH

// Register byte offsets
`define MTOM_A_CUR1    8'h00
`define MTOM_A_CUR2    8'h04
`define MTOM_A_MSEL    8'h08
`define MTOM_A_MSEL2   8'h0C
`define MTOM_A_UGRP    8'h10
`define MTOM_A_INFN    8'h14
`define MTOM_A_OUTFA   8'h18
`define MTOM_A_OUTFB   8'h1C
`define MTOM_A_STS     8'h20
`define MTOM_A_MASK    8'h24
`define MTOM_A_STATE   8'h28
`define MTOM_A_ACC1    8'h2C
`define MTOM_A_ACC2    8'h30
`define MTOM_A_CTRL    8'h34

// Setting codes and limits
`define MTOM_CUR_MAX   20'hC350
`define MTOM_CUR_INV   20'hF41DC
`define MTOM_CUR2_RST  20'hF41DC
`define MTOM_MSEL_RST  16'h0000
`define MTOM_SEL2_OFF  16'h270F
`define MTOM_CODE_RT   6'h03
`define MTOM_CODE_POS  7'h08
`define MTOM_CODE_NEG  7'h6C

// Level percentages
`define MTOM_PCT_PRE   7'h55
`define MTOM_PCT_TRIP  7'h64

// Status bits
`define MTOM_ST_PRE    0
`define MTOM_ST_FLT    1

// Timing
`define MTOM_TICK_NS   1000000
`define MTOM_CLK_NS    10

`endif

// ### sim/mtom_motor_model.sv
// Purpose: Motor and terminal side seen by the monitor
// Assumes: Current and select change only at clock edges
// Notes:   Terminals 1-4 stay low, nothing else is wired to them
`timescale 1ns/1ps
module mtom_motor_model (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire [19:0] loadSet,
   input  wire        selSet,
   output wire [19:0] outCurrent,
   output wire [4:0]  inTerm
);
   reg [19:0] curr_ff;   // Motor current, 0.01 A
   reg        sel_ff;    // Second-set request level
   // One flop of delay, like a real current sensor path
   always @(posedge ref_clk)
   begin
      if (rst)
      begin
         curr_ff <= 20'h00000;
         sel_ff  <= 1'b0;
      end
      else
      begin
         curr_ff <= loadSet;
         sel_ff  <= selSet;
      end
   end
   assign outCurrent = curr_ff;
   assign inTerm     = {4'h0, sel_ff};
endmodule // mtom_motor_model

// ### sim/mtom_monitor_sva.sv
// Purpose: Port-level checks of bus answers and trip flags
// Assumes: One clock, rst synchronous active high
// Notes:   Settings are not visible here, so checks stay relational
`timescale 1ns/1ps
module mtom_monitor_chk (
   input wire        ref_clk,
   input wire        rst,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        resetIn,
   input wire        thermalAlarmOut,
   input wire        thermalPrealarmIndication,
   input wire        motorOverloadFault
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Both write halves taken at one edge
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_answer; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write answer late");
   property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
   a_rd_answer: assert property (p_rd_answer)
      else $error("read answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("rdata dropped");
   property p_aw_block; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_aw_block: assert property (p_aw_block) else $error("aw open");
   property p_ar_block; s_axi_arready == !s_axi_rvalid; endproperty
   a_ar_block: assert property (p_ar_block) else $error("ar open");
   property p_pre_same; thermalPrealarmIndication == thermalAlarmOut;
   endproperty
   a_pre_same: assert property (p_pre_same)
      else $error("prealarm differs from alarm");
   // Trip lies above the alarm level, so it never comes alone
   property p_trip_alarm; $rose(motorOverloadFault) |-> thermalAlarmOut;
   endproperty
   a_trip_alarm: assert property (p_trip_alarm)
      else $error("trip without alarm");
   property p_fault_keep;
      motorOverloadFault && !resetIn |=> motorOverloadFault;
   endproperty
   a_fault_keep: assert property (p_fault_keep)
      else $error("fault dropped without reset");
endmodule // mtom_monitor_chk

bind mtom_monitor mtom_monitor_chk u_chk (.ref_clk(ref_clk), .rst(rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .resetIn(resetIn), .thermalAlarmOut(thermalAlarmOut),
   .thermalPrealarmIndication(thermalPrealarmIndication),
   .motorOverloadFault(motorOverloadFault));

// ### sim/motor_thermal_overload_monitor_bench.sv
// Purpose: Self-checking bench for the thermal overload monitor
// Assumes: Tick cut to 8 cycles; currents in 0.01 A
// Notes:   Bus tasks look at ready and valid at the falling edge
`timescale 1ns/1ps
`include "mtom_regs.vh"
module motor_thermal_overload_monitor_bench;
   logic        ref_clk = 1'b0;   // 100 MHz
   logic        rst = 1'b1;       // Sync reset
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0, resetIn = 1'b0;
   logic [19:0] loadSet = 20'h0;  // Wanted motor current
   logic        selSet = 1'b0;    // Wanted select level
   wire         awRdy, wRdy, bVal, arRdy, rVal, alarm, pre, fault, irq;
   wire  [1:0]  bResp, rResp;
   wire  [31:0] rData;
   wire  [19:0] outCurrent;
   wire  [4:0]  inTerm;
   wire  [5:0]  outTerm;
   wire  [15:0] constSel;
   wire         constOk;
   int          num_errors = 0, checks = 0;
   logic [31:0] d;                // Last read data
   logic [1:0]  r;                // Last response

   always #5 ref_clk = ~ref_clk;
   mtom_monitor #(.TICK_CYC(8)) u_dut (.ref_clk(ref_clk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(awRdy), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bVal),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arRdy),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rVal),
      .s_axi_rready(s_axi_rready), .inTerm(inTerm), .resetIn(resetIn),
      .outCurrent(outCurrent), .outTerm(outTerm),
      .thermalAlarmOut(alarm), .thermalPrealarmIndication(pre),
      .motorOverloadFault(fault), .motorConstSel(constSel),
      .motorConstValid(constOk), .irq(irq));

   mtom_motor_model u_motor (.ref_clk(ref_clk), .rst(rst),
      .loadSet(loadSet), .selSet(selSet), .outCurrent(outCurrent),
      .inTerm(inTerm));

   task automatic chk(input string what, input [31:0] e, input [31:0] g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask

   // Write; address and data offered together, each dropped when taken
   task automatic wr(input [7:0] a, input [31:0] v, input [1:0] e);
      bit aw, w, b;
      int n;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b = 0;
      for (n = 0; n < 50 && !b; n++)
      begin
         @(negedge ref_clk);
         aw = s_axi_awvalid & awRdy;
         w = s_axi_wvalid & wRdy;
         b = bVal;
         r = bResp;
         @(posedge ref_clk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (b) s_axi_bready <= 1'b0;
      end
      chk("bresp", {30'h0, e}, b ? {30'h0, r} : 32'hFFFF);
   endtask

   task automatic rd(input [7:0] a);
      bit ar, rv;
      int n;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rv = 0;
      for (n = 0; n < 50 && !rv; n++)
      begin
         @(negedge ref_clk);
         ar = s_axi_arvalid & arRdy;
         rv = rVal;
         d = rData;
         r = rResp;
         @(posedge ref_clk);
         if (ar) s_axi_arvalid <= 1'b0;
         if (rv) s_axi_rready <= 1'b0;
      end
      if (!rv) chk("rvalid", 32'h1, 32'h0);
   endtask

   task automatic do_reset;
      @(posedge ref_clk);
      rst <= 1'b1;
      loadSet <= 20'h0;
      selSet <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
   endtask

   // Bounded wait for the alarm (0) or the trip (1)
   task automatic wait_flag(input bit f);
      int n;
      for (n = 0; n < 4000 && (f ? fault : alarm) !== 1'b1; n++)
         @(negedge ref_clk);
   endtask

   // Reset values, ranges, write lock and motor-constant outputs
   task automatic t_regs;
      logic [7:0] codes [18] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06,
         8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h17, 8'h18, 8'h28, 8'h2B, 8'h2C,
         8'h32, 8'h35, 8'h36};
      rd(`MTOM_A_CUR2); chk("cur2 init", 32'h000F41DC, d);
      rd(`MTOM_A_MSEL); chk("msel init", 32'h0, d);
      rd(`MTOM_A_MSEL2); chk("msel2 init", 32'h270F, d);
      rd(8'h3C); chk("unmapped", 32'h3, {30'h0, r}); // Unused slot
      wr(`MTOM_A_CUR2, 32'hC351, 2'b10);
      rd(`MTOM_A_CUR2); chk("cur2 kept", 32'h000F41DC, d);
      wr(`MTOM_A_CUR2, 32'hC350, 2'b00);
      wr(`MTOM_A_CUR2, 32'h0, 2'b00);
      foreach (codes[i]) wr(`MTOM_A_MSEL, {24'h0, codes[i]}, 2'b00);
      wr(`MTOM_A_MSEL, 32'h2, 2'b10);
      wr(`MTOM_A_MSEL2, 32'h1, 2'b00);
      wr(`MTOM_A_MSEL2, 32'h2, 2'b10);
      wr(`MTOM_A_UGRP, 32'h1, 2'b00);
      wr(`MTOM_A_MSEL, 32'hD, 2'b10);
      wr(`MTOM_A_MSEL2, 32'h0, 2'b10);
      wr(`MTOM_A_UGRP, 32'h0, 2'b00);
      wr(`MTOM_A_MSEL, 32'hD, 2'b00);
      wr(`MTOM_A_CTRL, 32'h1, 2'b00);
      repeat (3) @(negedge ref_clk);
      chk("const sel", 32'hD, {16'h0, constSel});
      chk("const ok", 32'h1, {31'h0, constOk});
   endtask

   // One setting row: expected {m2Cool,m1Cool,m2Act,m1Act}
   task automatic row(input [19:0] c1, c2, input s, input [3:0] e);
      wr(`MTOM_A_CUR1, {12'h0, c1}, 2'b00);
      wr(`MTOM_A_CUR2, {12'h0, c2}, 2'b00);
      @(posedge ref_clk);
      selSet <= s;
      repeat (5) @(posedge ref_clk);
      rd(`MTOM_A_STATE);
      chk("model state", {28'h0, e}, {28'h0, d[6:3]});
   endtask

   task automatic t_states;
      do_reset;
      row(20'h2710, 20'h1388, 1'b1, 4'b1011);
      wr(`MTOM_A_INFN, 32'h3, 2'b00);
      row(20'h2710, 20'h1388, 1'b1, 4'b0111);
      row(20'h2710, 20'h1388, 1'b0, 4'b1011);
      row(20'h2710, `MTOM_CUR_INV, 1'b1, 4'b0001);
      row(20'h2710, 20'h0, 1'b1, 4'b0101);
      row(20'h0, 20'h0, 1'b0, 4'b0000);
      // 60 A on a 50 A second set: only that set can alarm
      row(20'h2710, 20'h1388, 1'b1, 4'b0111);
      @(posedge ref_clk);
      loadSet <= 20'h1770;
      wait_flag(0);
      chk("alarm on set 2", 32'h1, {31'h0, alarm});
   endtask

   // 120 A on 100 A: alarm, outputs, trip, latch, clear
   task automatic t_overload;
      do_reset;
      wr(`MTOM_A_OUTFA, 32'h8, 2'b00);
      wr(`MTOM_A_OUTFB, 32'h6C, 2'b00);
      wr(`MTOM_A_MASK, 32'h3, 2'b00);
      repeat (3) @(negedge ref_clk);
      chk("terms idle", 32'h8, {26'h0, outTerm} & 32'h9);
      @(posedge ref_clk);
      loadSet <= 20'h2EE0;
      wait_flag(0);
      chk("no trip at alarm", 32'h0, {31'h0, fault});
      chk("prealarm", 32'h1, {31'h0, pre});
      chk("irq", 32'h1, {31'h0, irq});
      repeat (2) @(negedge ref_clk);
      chk("terms alarm", 32'h1, {26'h0, outTerm} & 32'h9);
      wait_flag(1);
      chk("trip", 32'h1, {31'h0, fault});
      @(posedge ref_clk);
      loadSet <= 20'h0;
      repeat (40) @(negedge ref_clk);
      chk("trip latched", 32'h1, {31'h0, fault});
      rd(`MTOM_A_STS); chk("events", 32'h3, d & 32'h3);
      rd(`MTOM_A_STS); chk("events cleared", 32'h0, d & 32'h3);
      chk("irq cleared", 32'h0, {31'h0, irq});
      @(posedge ref_clk);
      resetIn <= 1'b1;
      @(posedge ref_clk);
      resetIn <= 1'b0;
      @(negedge ref_clk);
      chk("trip cleared", 32'h0, {31'h0, fault});
   endtask

   task automatic end_of_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Whole run needs well under 20000 cycles
   initial
   begin
      #400000;
      num_errors++;
      end_of_test;
   end

   initial
   begin
      do_reset;
      t_regs;
      t_states;
      t_overload;
      end_of_test;
   end
endmodule // motor_thermal_overload_monitor_bench
